// *** hdl/dcc_pkg.sv ***
// shared constants and types for the calibration control register group
package dcc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_SERIAL_CTL = 5'h00;
    localparam logic [4:0] ADDR_DATA_CFG = 5'h02;
    localparam logic [4:0] ADDR_HW_REVISION = 5'h0d;
    localparam logic [4:0] ADDR_CAL_SRC_DIV = 5'h0e;
    localparam logic [4:0] ADDR_CAL_COMMAND = 5'h0f;
    localparam logic [4:0] ADDR_COEF_INDEX = 5'h10;
    localparam logic [4:0] ADDR_COEF_VALUE = 5'h11;
    localparam logic [4:0] ADDR_CAL_DAC_RANGE = 5'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_REF_SOURCE_SELECT = 0;
    localparam int BIT_CAL_CLK_GATE = 0;
    localparam int BIT_CAL_DONE = 7;
    localparam int BIT_CAL_START = 6;
    localparam int BIT_COEF_STORE = 3;
    localparam int BIT_COEF_FETCH = 2;
    localparam int BIT_COEF_DEFAULT = 0;
    localparam int BIT_CAL_DAC_HALF = 4;
    localparam int LSB_COEF_SOURCE = 4;
    localparam int LSB_DIV_SEL = 0;

    // ------------------------------------------------------------
    // widths, reset values and constants
    // ------------------------------------------------------------
    localparam int COEF_W = 6;
    localparam int COEF_DEPTH = 64;
    localparam logic [5:0] RST_COEF_INDEX = 6'h00;
    localparam logic [5:0] RST_COEF_VALUE = 6'h3f;
    localparam logic [2:0] RST_DIV_SEL = 3'h0;
    // default (uncalibrated) trim held by every entry after a coefficient reset
    localparam logic [5:0] COEF_DEFAULT = 6'h20;
    // arbitrary revision value
    localparam logic [3:0] HW_REVISION = 4'h5;
    // the longest divide ratio is 256 converter clocks
    localparam logic [7:0] DIV_MAX_TERM = 8'hff;

    typedef enum logic [1:0] {
        SRC_COEF_DEFAULT_CMD = 2'b00,
        SRC_SELF = 2'b01,
        SRC_UNUSED = 2'b10,
        SRC_USER = 2'b11
    } dcc_src_t;

endpackage : dcc_pkg

// *** hdl/dcc_if.sv ***
// register access link between the host controller and the device
`timescale 1ns/1ps
interface dcc_if;
    logic wr_en;
    logic rd_en;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;

    modport device (
        input wr_en, rd_en, addr, wdata,
        output rdata, rvalid
    );
    modport host (
        output wr_en, rd_en, addr, wdata,
        input rdata, rvalid
    );
endinterface : dcc_if

// *** hdl/dcc_device.sv ***
// device end: calibration control registers, divider, sequencer and coefficient memory
//
// Operation
// - read-only 4-bit revision field, writes ignored
// - read-only source status, resets uncalibrated
// - divider code selects calibration clock ratio
// - done flag set when calibration finishes
// - writing start launches self-calibration
// - store command writes value into indexed entry
// - fetch command loads indexed entry into value
// - default command resets every coefficient
// - 6-bit index register, resets zero
// - 6-bit value register, resets all ones
// - trim bit selects half-range calibration DAC
// - serial control bit0 selects external reference
// - data config bit0 gates calibration clock
`timescale 1ns/1ps
module dcc_device
    import dcc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register link
    dcc_if.device bus,
    // measurement from the analog comparator, asynchronous
    input wire logic [5:0] cal_measure_in,
    // control outputs
    output logic ref_source_select_out,
    output logic cal_dac_half_range_out,
    output logic cal_clk_en_out,
    output logic cal_busy_out,
    output logic [5:0] cal_step_index_out
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic ref_source_select;
    logic cal_clk_gate;
    logic [2:0] cal_clk_div_sel;
    dcc_src_t coef_source_status;
    logic cal_done_flag;
    logic cal_start_cmd;
    logic coef_store_cmd;
    logic coef_fetch_cmd;
    logic coef_default_cmd;
    logic [5:0] coef_index;
    logic [5:0] coef_value;
    logic cal_dac_half_range;
    logic [5:0] coef_mem [COEF_DEPTH];
    logic [7:0] div_count;
    logic [7:0] div_term;
    logic cal_tick;
    logic [5:0] meas_meta;
    logic [5:0] meas_sync;
    logic [5:0] step;
    logic step_last;
    logic cmd_wr;

    assign cmd_wr = bus.wr_en && (bus.addr == ADDR_CAL_COMMAND);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ref_source_select <= 1'b0;
            cal_clk_gate <= 1'b0;
            cal_clk_div_sel <= RST_DIV_SEL;
            coef_index <= RST_COEF_INDEX;
            cal_dac_half_range <= 1'b0;
        end else if (bus.wr_en) begin
            case (bus.addr)
                ADDR_SERIAL_CTL: ref_source_select <= bus.wdata[BIT_REF_SOURCE_SELECT];
                ADDR_DATA_CFG: cal_clk_gate <= bus.wdata[BIT_CAL_CLK_GATE];
                ADDR_CAL_SRC_DIV: cal_clk_div_sel <= bus.wdata[LSB_DIV_SEL +: 3];
                ADDR_COEF_INDEX: coef_index <= bus.wdata[5:0];
                ADDR_CAL_DAC_RANGE: cal_dac_half_range <= bus.wdata[BIT_CAL_DAC_HALF];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // calibration clock divider
    // ------------------------------------------------------------
    // code 0 gives 256 down to code 7 giving 2
    assign div_term = 8'(DIV_MAX_TERM >> cal_clk_div_sel);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            div_count <= 8'h00;
            cal_tick <= 1'b0;
        end else if (!cal_clk_gate) begin
            // gate closed clears the divider and holds it at zero
            div_count <= 8'h00;
            cal_tick <= 1'b0;
        end else if (div_count >= div_term) begin
            // >= so a ratio change mid-count never overruns
            div_count <= 8'h00;
            cal_tick <= 1'b1;
        end else begin
            div_count <= div_count + 8'h01;
            cal_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // measurement synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meas_meta <= 6'h00;
            meas_sync <= 6'h00;
        end else begin
            meas_meta <= cal_measure_in;
            meas_sync <= meas_meta;
        end
    end

    // ------------------------------------------------------------
    // self-calibration sequencer
    // ------------------------------------------------------------
    // one entry is trimmed per calibration clock; a closed gate stalls it
    assign step_last = cal_start_cmd && cal_tick && (step == 6'h3f);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cal_start_cmd <= 1'b0;
            step <= 6'h00;
        end else if (cmd_wr && bus.wdata[BIT_CAL_START] && !cal_start_cmd) begin
            cal_start_cmd <= 1'b1;
            step <= 6'h00;
        end else if (step_last) begin
            // start bit clears when the sequence ends
            cal_start_cmd <= 1'b0;
            step <= 6'h00;
        end else if (cal_start_cmd && cal_tick) begin
            step <= step + 6'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cal_done_flag <= 1'b0;
        end else if (step_last) begin
            // done set at the end of the sequence
            cal_done_flag <= 1'b1;
        end else if (cmd_wr && bus.wdata[BIT_CAL_START] && !cal_start_cmd) begin
            cal_done_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // coefficient commands
    // ------------------------------------------------------------
    // each command bit stands one cycle while its action runs
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            coef_store_cmd <= 1'b0;
            coef_fetch_cmd <= 1'b0;
            coef_default_cmd <= 1'b0;
        end else begin
            coef_store_cmd <= cmd_wr && bus.wdata[BIT_COEF_STORE];
            coef_fetch_cmd <= cmd_wr && bus.wdata[BIT_COEF_FETCH];
            coef_default_cmd <= cmd_wr && bus.wdata[BIT_COEF_DEFAULT];
        end
    end

    // the default command wins over store and over a calibration step
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || coef_default_cmd) begin
            // every entry returns to its default
            for (int i = 0; i < COEF_DEPTH; i++) begin
                coef_mem[i] <= COEF_DEFAULT;
            end
        end else if (coef_store_cmd) begin
            // store value into the indexed entry
            coef_mem[coef_index] <= coef_value;
        end else if (cal_start_cmd && cal_tick) begin
            coef_mem[step] <= meas_sync;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            coef_value <= RST_COEF_VALUE;
        end else if (coef_fetch_cmd) begin
            // fetch indexed entry into the value register
            coef_value <= coef_mem[coef_index];
        end else if (bus.wr_en && bus.addr == ADDR_COEF_VALUE) begin
            coef_value <= bus.wdata[5:0];
        end
    end

    // source status follows the last action on the memory
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || coef_default_cmd) begin
            coef_source_status <= SRC_COEF_DEFAULT_CMD;
        end else if (coef_store_cmd) begin
            coef_source_status <= SRC_USER;
        end else if (step_last) begin
            coef_source_status <= SRC_SELF;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            bus.rdata <= 8'h00;
            bus.rvalid <= 1'b0;
        end else begin
            bus.rvalid <= bus.rd_en;
            bus.rdata <= 8'h00;
            if (bus.rd_en) begin
                case (bus.addr)
                    ADDR_SERIAL_CTL: bus.rdata <= {7'h00, ref_source_select};
                    ADDR_DATA_CFG: bus.rdata <= {7'h00, cal_clk_gate};
                    // revision is a constant, never written
                    ADDR_HW_REVISION: bus.rdata <= {4'h0, HW_REVISION};
                    ADDR_CAL_SRC_DIV: bus.rdata <= {2'b00, coef_source_status, 1'b0,
                        cal_clk_div_sel};
                    ADDR_CAL_COMMAND: bus.rdata <= {cal_done_flag, cal_start_cmd, 2'b00,
                        coef_store_cmd, coef_fetch_cmd, 1'b0, coef_default_cmd};
                    ADDR_COEF_INDEX: bus.rdata <= {2'b00, coef_index};
                    ADDR_COEF_VALUE: bus.rdata <= {2'b00, coef_value};
                    ADDR_CAL_DAC_RANGE: bus.rdata <= {3'h0, cal_dac_half_range, 4'h0};
                    default: bus.rdata <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ref_source_select_out <= 1'b0;
            cal_dac_half_range_out <= 1'b0;
            cal_busy_out <= 1'b0;
            cal_step_index_out <= 6'h00;
        end else begin
            ref_source_select_out <= ref_source_select;
            cal_dac_half_range_out <= cal_dac_half_range;
            cal_busy_out <= cal_start_cmd;
            cal_step_index_out <= step;
        end
    end

    assign cal_clk_en_out = cal_tick;

endmodule : dcc_device

// *** hdl/dcc_host.sv ***
// host end: issues single register writes and reads over the link
`timescale 1ns/1ps
module dcc_host
    import dcc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register link
    dcc_if.host bus,
    // user request
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [4:0] req_addr_in,
    input wire logic [7:0] req_wdata_in,
    output logic req_ready_out,
    // user response
    output logic resp_valid_out,
    output logic [7:0] resp_data_out
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_WAIT
    } dcc_host_state_t;

    dcc_host_state_t state;

    assign req_ready_out = (state == ST_IDLE);

    // ------------------------------------------------------------
    // request sequencer
    // ------------------------------------------------------------
    // command writes pass through unchanged as one strobe
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            bus.wr_en <= 1'b0;
            bus.rd_en <= 1'b0;
            bus.addr <= 5'h00;
            bus.wdata <= 8'h00;
        end else begin
            bus.wr_en <= 1'b0;
            bus.rd_en <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (req_valid_in) begin
                        bus.addr <= req_addr_in;
                        bus.wdata <= req_wdata_in;
                        bus.wr_en <= req_write_in;
                        bus.rd_en <= !req_write_in;
                        state <= req_write_in ? ST_ISSUE : ST_WAIT;
                    end
                end
                // one spare cycle lets a command settle before the next access
                ST_ISSUE: state <= ST_IDLE;
                ST_WAIT: begin
                    if (bus.rvalid) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            resp_valid_out <= 1'b0;
            resp_data_out <= 8'h00;
        end else begin
            resp_valid_out <= (state == ST_WAIT) && bus.rvalid;
            if ((state == ST_WAIT) && bus.rvalid) begin
                resp_data_out <= bus.rdata;
            end
        end
    end

endmodule : dcc_host

// *** verif/dcc_link_sva.sv ***
// assertions on the register link between host end and device end
`timescale 1ns/1ps
module dcc_link_sva
    import dcc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // link signals
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    logic [5:0] index_shadow;
    logic half_shadow;

    // ------------------------------------------------------------
    // shadows of host-written fields
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            index_shadow <= RST_COEF_INDEX;
        end else if (wr_en && addr == ADDR_COEF_INDEX) begin
            index_shadow <= wdata[5:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            half_shadow <= 1'b0;
        end else if (wr_en && addr == ADDR_CAL_DAC_RANGE) begin
            half_shadow <= wdata[BIT_CAL_DAC_HALF];
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    read_answer_a: assert property (rd_en |=> rvalid)
        else $error("read strobe without answer next cycle");
    no_stray_a: assert property (!rd_en |=> !rvalid)
        else $error("answer without read strobe");
    idle_data_a: assert property (!rvalid |-> rdata == 8'h00)
        else $error("read data not zero while idle");
    strobe_spacing_a: assert property (wr_en |=> !wr_en && !rd_en)
        else $error("write strobe not a lone pulse");
    revision_read_a: assert property (
        rd_en && addr == ADDR_HW_REVISION |=> rdata == {4'h0, HW_REVISION})
        else $error("revision register read wrong");
    index_readback_a: assert property (
        rd_en && addr == ADDR_COEF_INDEX |=> rdata == {2'b00, index_shadow})
        else $error("index read back wrong");
    trim_readback_a: assert property (
        rd_en && addr == ADDR_CAL_DAC_RANGE |=> rdata == {3'b000, half_shadow, 4'h0})
        else $error("range register read back wrong");
    status_field_a: assert property (
        rd_en && addr == ADDR_CAL_SRC_DIV |=> rdata[7:6] == 2'b00 && !rdata[3]
        && rdata[5:4] != SRC_UNUSED)
        else $error("status register bad field");
    value_width_a: assert property (
        rd_en && addr == ADDR_COEF_VALUE |=> rdata[7:6] == 2'b00)
        else $error("value register upper bits set");
    unmapped_read_a: assert property (rd_en && addr == 5'h1f |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    cover property (rd_en && addr == ADDR_HW_REVISION);
    cover property (wr_en && addr == ADDR_CAL_COMMAND && wdata[BIT_CAL_START]);
    cover property (wr_en && addr == ADDR_CAL_COMMAND && wdata[BIT_COEF_STORE]);
endmodule : dcc_link_sva

// *** verif/dac_calibration_control_test.sv ***
// testbench joining host end and device end over the register link
`timescale 1ns/1ps
module dac_calibration_control_test;
    import dcc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, rv, rw, ready, resp_v, ref_sel, half, clk_en, busy;
    logic [4:0] ra;
    logic [7:0] rwd, resp_d, rdv;
    logic [5:0] step;
    int errors = 0, num_checks = 0, g, n;
    dcc_if link();

    dcc_host u_dcc_host(.clk_in(clk), .rst_n_in(rst_n), .bus(link.host), .req_valid_in(rv),
        .req_write_in(rw), .req_addr_in(ra), .req_wdata_in(rwd), .req_ready_out(ready),
        .resp_valid_out(resp_v), .resp_data_out(resp_d));
    dcc_device u_dcc_device(.clk_in(clk), .rst_n_in(rst_n), .bus(link.device),
        .cal_measure_in(6'h2a), .ref_source_select_out(ref_sel),
        .cal_dac_half_range_out(half), .cal_clk_en_out(clk_en), .cal_busy_out(busy),
        .cal_step_index_out(step));
    dcc_link_sva u_sva(.clk_in(clk), .rst_n_in(rst_n), .wr_en(link.wr_en),
        .rd_en(link.rd_en), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
        .rvalid(link.rvalid));

    initial begin
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    // ready is sampled at the falling edge, so the taking edge is never raced
    task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        rv <= 1'b1;
        rw <= w;
        ra <= a;
        rwd <= d;
        for (n = 0; n < 50 && ready !== 1'b1; n++) @(negedge clk);
        if (n == 50) begin
            check(16'h1, 16'h0, "ready wait");
            close_out();
        end
        @(posedge clk);
        rv <= 1'b0;
        for (n = 0; !w && n < 50 && resp_v !== 1'b1; n++) @(negedge clk);
        rdv = resp_d;
        if (n == 50) begin
            check(16'h1, 16'h0, "link wait");
            close_out();
        end
    endtask : access

    task automatic expect_reg(input logic [4:0] a, input logic [7:0] e);
        access(1'b0, a, 8'h00);
        check({8'h00, rdv}, {8'h00, e}, "register read");
    endtask : expect_reg

    // cycles between two divided ticks, 600 means none seen
    task automatic gap();
        for (n = 0; n < 600 && clk_en !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
        for (g = 1; g < 600 && clk_en !== 1'b1; g++) @(negedge clk);
    endtask : gap

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        logic [4:0] adr [9] = '{5'h00, 5'h02, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h14, 5'h1f};
        logic [7:0] val [9] = '{8'h00, 8'h00, {4'h0, HW_REVISION}, 8'h00, 8'h00, 8'h00,
            8'h3f, 8'h00, 8'h00};
        foreach (adr[i]) expect_reg(adr[i], val[i]);
        access(1'b1, ADDR_HW_REVISION, 8'hff);
        expect_reg(ADDR_HW_REVISION, {4'h0, HW_REVISION});
        access(1'b1, ADDR_CAL_SRC_DIV, 8'hff);
        expect_reg(ADDR_CAL_SRC_DIV, 8'h07);
    endtask : t_reset_values

    task automatic t_divider();
        access(1'b1, ADDR_DATA_CFG, 8'h01);
        for (int c = 0; c < 8; c++) begin
            access(1'b1, ADDR_CAL_SRC_DIV, 8'(c));
            gap();
            gap();
            check(16'(g), 16'(256 >> c), "divide ratio");
        end
        access(1'b1, ADDR_DATA_CFG, 8'h00);
        repeat (4) @(negedge clk);
        gap();
        check(16'(g), 16'd600, "gated divider");
    endtask : t_divider

    task automatic t_self_cal();
        access(1'b1, ADDR_DATA_CFG, 8'h01);
        for (int k = 0; k < 2; k++) begin
            access(1'b1, ADDR_CAL_COMMAND, 8'h40);
            expect_reg(ADDR_CAL_COMMAND, 8'h40);
            check({15'h0, busy}, 16'h1, "busy");
            for (g = 0; g < 200; g++) begin
                access(1'b0, ADDR_CAL_COMMAND, 8'h00);
                if (rdv[BIT_CAL_DONE] === 1'b1) break;
            end
            check({8'h00, rdv}, 16'h0080, "done");
            check({9'h0, step, busy}, 16'h0, "sequencer idle");
            expect_reg(ADDR_CAL_SRC_DIV, 8'h17);
        end
        // entry 0 holds the synchronised measurement word after a run
        access(1'b1, ADDR_CAL_COMMAND, 8'h04);
        expect_reg(ADDR_COEF_VALUE, 8'h2a);
    endtask : t_self_cal

    task automatic t_coef();
        access(1'b1, ADDR_COEF_INDEX, 8'h3f);
        access(1'b1, ADDR_COEF_VALUE, 8'h15);
        access(1'b1, ADDR_CAL_COMMAND, 8'h08);
        expect_reg(ADDR_CAL_COMMAND, 8'h80);
        expect_reg(ADDR_CAL_SRC_DIV, 8'h37);
        access(1'b1, ADDR_COEF_VALUE, 8'h00);
        access(1'b1, ADDR_CAL_COMMAND, 8'h04);
        expect_reg(ADDR_COEF_VALUE, 8'h15);
        access(1'b1, ADDR_CAL_COMMAND, 8'h01);
        access(1'b1, ADDR_CAL_COMMAND, 8'h04);
        expect_reg(ADDR_COEF_VALUE, {2'b00, COEF_DEFAULT});
        expect_reg(ADDR_CAL_SRC_DIV, 8'h07);
        expect_reg(ADDR_COEF_INDEX, 8'h3f);
    endtask : t_coef

    task automatic t_outputs();
        access(1'b1, ADDR_SERIAL_CTL, 8'h01);
        expect_reg(ADDR_SERIAL_CTL, 8'h01);
        check({15'h0, ref_sel}, 16'h1, "reference select");
        access(1'b1, ADDR_CAL_DAC_RANGE, 8'h10);
        expect_reg(ADDR_CAL_DAC_RANGE, 8'h10);
        check({15'h0, half}, 16'h1, "half range");
    endtask : t_outputs

    // a second reset mid-run must bring every register and output back
    task automatic t_mid_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check({6'h0, step, busy, half, ref_sel, clk_en}, 16'h0, "outputs after reset");
        t_reset_values();
    endtask : t_mid_reset

    initial begin
        rv = 1'b0;
        rw = 1'b0;
        ra = 5'h00;
        rwd = 8'h00;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_divider();
        t_self_cal();
        t_coef();
        t_outputs();
        t_mid_reset();
        close_out();
    end
endmodule : dac_calibration_control_test
